// [include/ctb_regs.vh]
// register offsets, field positions, reset values and timing counts
`ifndef CTB_REGS_VH
`define CTB_REGS_VH
`define CTB_A_CTL      12'h000
`define CTB_A_BIT      12'h00C
`define CTB_A_TST      12'h014
`define CTB_A_BRPE     12'h018
`define CTB_A_IF1CRQ   12'h020
`define CTB_A_IF1ARB2  12'h034
`define CTB_A_IF1MCTL  12'h038
`define CTB_A_IF1DA1   12'h03C
`define CTB_A_IF1DA2   12'h040
`define CTB_A_IF1DB1   12'h044
`define CTB_A_IF1DB2   12'h048
`define CTB_A_IF2CRQ   12'h080
`define CTB_A_IF2ARB2  12'h094
`define CTB_A_IF2MCTL  12'h098
`define CTB_A_IF2DA1   12'h09C
`define CTB_A_IF2DA2   12'h0A0
`define CTB_A_IF2DB1   12'h0A4
`define CTB_A_IF2DB2   12'h0A8
`define CTB_CTL_INIT   0
`define CTB_CTL_TEST   7
`define CTB_TST_BASIC  2
`define CTB_TST_SILENT 3
`define CTB_TST_LOOPBACK_SELECT  4
`define CTB_TST_TXLO   5
`define CTB_TST_RX     7
`define CTB_CRQ_BUSY   15
`define CTB_MC_NEW_DATA_FLAG  15
`define CTB_MC_MESSAGE_LOST_FLAG  14
`define CTB_RST_CTL    8'h01
`define CTB_RST_BIT    15'h2301
`define CTB_RST_CRQ    6'h01
`define CTB_CRC_POLY   15'h4599
`define CTB_HDR_BITS   7'h12
`define CTB_CRC_BITS   7'h0F
`define CTB_ARB_BITS   7'h0C
`define CTB_STUFF_RUN  3'h5
`define CTB_IDLE_BITS  7'h0B
`define CTB_EOF_BITS   7'h07
`define CTB_EOFINT_END 7'h09
`define CTB_FLAG_END   7'h05
`endif

// [rtl/ctb_can_core.v]
// can test modes, bit timing engine, basic-mode frame engine, axi4-lite regs
`timescale 1ns/10ps
`include "ctb_regs.vh"
module ctb_can_core (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bus_rx_pin,
  output wire        bus_tx_pin
);
  localparam S_WAIT = 3'h0, S_IDLE = 3'h1, S_FRM = 3'h2, S_CDEL = 3'h3;
  localparam S_ACK = 3'h4, S_ADEL = 3'h5, S_EOF = 3'h6, S_ERR = 3'h7;

  // known register offsets
  function mapped;
    input [11:0] a;
    begin
      case (a)
        `CTB_A_CTL, `CTB_A_BIT, `CTB_A_TST, `CTB_A_BRPE, `CTB_A_IF1CRQ,
        `CTB_A_IF1ARB2, `CTB_A_IF1MCTL, `CTB_A_IF1DA1, `CTB_A_IF1DA2,
        `CTB_A_IF1DB1, `CTB_A_IF1DB2, `CTB_A_IF2CRQ, `CTB_A_IF2ARB2,
        `CTB_A_IF2MCTL, `CTB_A_IF2DA1, `CTB_A_IF2DA2, `CTB_A_IF2DB1,
        `CTB_A_IF2DB2: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // byte-lane merge of a 16-bit register
  function [15:0] mg;
    input [15:0] o;
    input [15:0] n;
    input [1:0]  s;
    begin
      mg = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    end
  endfunction

  // can crc-15, one bit
  function [14:0] crcn;
    input [14:0] c;
    input        b;
    begin
      crcn = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? `CTB_CRC_POLY : 15'h0000);
    end
  endfunction

  function [15:0] sw16;
    input [15:0] x;
    begin
      sw16 = {x[7:0], x[15:8]};
    end
  endfunction

  reg  [7:0]  ctl_r;
  reg  [6:2]  tst_r;
  reg  [14:0] bit_r;
  reg  [3:0]  brpe_r;
  reg         if1_busy_r;
  reg  [5:0]  if1_num_r;
  reg  [15:0] if1_arb_r;
  reg  [15:0] if1_mc_r;
  reg  [63:0] if1_d_r;
  reg         if2_busy_r;
  reg  [5:0]  if2_num_r;
  reg  [10:0] if2_id_r;
  reg  [3:0]  if2_dlc_r;
  reg         new_data_flag_r;
  reg         message_lost_flag_r;
  reg  [63:0] if2_b_r;
  reg         s1_r, s2_r;
  reg  [9:0]  pc_r;
  reg  [4:0]  qc_r, sp_r, be_r;
  reg         rxq_r, txi_r, pin_r;
  reg  [2:0]  st_r, st_nxt;
  reg  [6:0]  cnt_r, cnt_nxt;
  reg  [81:0] sh_r, sh_nxt;
  reg  [14:0] crc_r, crc_nxt;
  reg  [2:0]  run_r, run_nxt;
  reg  [3:0]  dlc_r, dlc_nxt;
  reg         last_r, last_nxt, stf_r, stf_nxt;
  reg         txa_r, txa_nxt, txq_r, txq_nxt;
  reg         done_tx, done_rx, err;
  reg         aw_h_r, w_h_r, bv_r, rv_r;
  reg  [11:0] aw_a_r;
  reg  [15:0] w_d_r;
  reg  [1:0]  w_s_r, bresp_r, rresp_r;
  reg  [31:0] rd_r;
  reg  [15:0] rdv;

  // test bits act only with test enable
  wire test_en = ctl_r[`CTB_CTL_TEST];
  wire basic   = test_en & tst_r[`CTB_TST_BASIC];
  wire silent  = test_en & tst_r[`CTB_TST_SILENT];
  wire loopback_select   = test_en & tst_r[`CTB_TST_LOOPBACK_SELECT];
  wire [1:0] txsel = test_en ? tst_r[6:5] : 2'b00;
  wire init    = ctl_r[`CTB_CTL_INIT];

  // internal receive path; loopback cuts the pin off
  wire rx_int = loopback_select ? txi_r :
                silent ? (s2_r & txi_r) : s2_r;

  // quantum tick: prescaler and extension form one 10-bit divider
  wire [9:0] brp = {brpe_r, bit_r[5:0]};
  // reaching or passing the limit ends a quantum, so a smaller prescaler
  // written mid-count cannot stall the tick until the counter wraps
  wire       tq  = (pc_r >= brp);
  wire [4:0] sjw1 = {3'b000, bit_r[7:6]} + 5'h01;
  wire [4:0] nsp  = {1'b0, bit_r[11:8]} + 5'h01;
  wire [4:0] nbe  = {1'b0, bit_r[11:8]} + {2'b00, bit_r[14:12]} + 5'h02;
  wire       fall = tq & rxq_r & ~rx_int;
  wire       hard = fall & (st_r == S_IDLE);
  wire       infr = (st_r != S_IDLE) & (st_r != S_WAIT);
  wire       spp  = tq & (qc_r == sp_r) & (qc_r != 5'h00);
  wire       bs   = tq & (hard | (qc_r == be_r));
  wire [4:0] eb   = (qc_r <= sp_r) ? qc_r : (be_r - qc_r);
  wire [4:0] m    = (eb < sjw1) ? eb : sjw1;
  wire       b    = rx_int;

  // data length clipped to eight bytes
  wire [3:0] dlcc  = dlc_r[3] ? 4'h8 : dlc_r;
  wire [3:0] dlcn  = dlc_nxt[3] ? 4'h8 : dlc_nxt;
  wire [6:0] nd    = `CTB_HDR_BITS + {dlcc, 3'b000};
  wire [6:0] ndn   = `CTB_HDR_BITS + {dlcn, 3'b000};
  wire [6:0] sa    = 7'h40 - {dlcc, 3'b000};
  wire [81:0] al   = sh_r << sa;
  wire        pend = basic & if1_busy_r & (~silent | loopback_select);
  wire [63:0] txv;

  // tx vector in bus order, byte 0 first
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_tx
      assign txv[63-16*k -: 16] = sw16(if1_d_r[16*k+15 -: 16]);
    end
  endgenerate

  // receive pin synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= bus_rx_pin;
      s2_r <= s1_r;
    end
  end

  // prescaler and quantum counter with hard and soft resync
  always @(posedge aclk) begin
    if (!aresetn || init) begin
      pc_r  <= 10'h000;
      qc_r  <= 5'h00;
      sp_r  <= 5'h01;
      be_r  <= 5'h02;
      rxq_r <= 1'b1;
    end else begin
      pc_r <= tq ? 10'h000 : pc_r + 10'h001;
      if (tq) begin
        rxq_r <= rx_int;
        if (hard) begin
          qc_r <= 5'h01;
          sp_r <= nsp;
          be_r <= nbe;
        end else if (qc_r == be_r) begin
          qc_r <= 5'h00;
          sp_r <= nsp;
          be_r <= nbe;
        end else if (fall && infr && qc_r != 5'h00) begin
          if (qc_r <= sp_r) begin                          // lengthen phase 1
            sp_r <= sp_r + m;
            be_r <= be_r + m;
            qc_r <= qc_r + 5'h01;
          end else if (be_r - m <= qc_r) begin             // shorten phase 2
            qc_r <= 5'h00;
            sp_r <= nsp;
            be_r <= nbe;
          end else begin
            be_r <= be_r - m;
            qc_r <= qc_r + 5'h01;
          end
        end else begin
          qc_r <= qc_r + 5'h01;
        end
      end
    end
  end

  // frame engine, evaluated on each sample point
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    crc_nxt = crc_r;
    run_nxt = run_r;
    dlc_nxt = dlc_r;
    last_nxt = last_r;
    stf_nxt = stf_r;
    txa_nxt = txa_r;
    txq_nxt = txq_r;
    done_tx = 1'b0;
    done_rx = 1'b0;
    err = 1'b0;
    if (init) begin
      st_nxt = S_WAIT;
      cnt_nxt = 7'h00;
      txa_nxt = 1'b0;
      txq_nxt = 1'b1;
    end else if (spp) begin
      case (st_r)
        S_WAIT: begin
          if (!b) cnt_nxt = 7'h00;
          else if (cnt_r == `CTB_IDLE_BITS - 7'h01) st_nxt = S_IDLE;
          else cnt_nxt = cnt_r + 7'h01;
        end
        S_IDLE: begin
          if (!b) begin
            st_nxt = S_FRM;
            cnt_nxt = 7'h00;
            crc_nxt = 15'h0000;
            last_nxt = 1'b0;
            run_nxt = 3'h1;
            stf_nxt = 1'b0;
            dlc_nxt = 4'hF;
            txq_nxt = txa_r ? sh_r[81] : 1'b1;
          end else if (pend) begin
            txa_nxt = 1'b1;
            sh_nxt = {if1_arb_r[12:2], 3'b000, if1_mc_r[3:0], txv};
            txq_nxt = 1'b0;
          end
        end
        S_FRM: begin
          if (txa_r && b != txq_r) begin
            if (!stf_r && cnt_r < `CTB_ARB_BITS && txq_r) txa_nxt = 1'b0;
            else err = 1'b1;
          end
          if (stf_r) begin
            if (b == last_r) err = 1'b1;
            last_nxt = b;
            run_nxt = 3'h1;
            stf_nxt = 1'b0;
          end else begin
            if (cnt_r < nd) sh_nxt = {sh_r[80:0], b};
            crc_nxt = crcn(crc_r, b);
            cnt_nxt = cnt_r + 7'h01;
            run_nxt = (b == last_r) ? run_r + 3'h1 : 3'h1;
            last_nxt = b;
            stf_nxt = (run_nxt == `CTB_STUFF_RUN);
            if (cnt_nxt == `CTB_HDR_BITS) dlc_nxt = sh_nxt[3:0];
          end
          if (cnt_nxt == ndn + `CTB_CRC_BITS && !stf_nxt) begin
            st_nxt = S_CDEL;
            txq_nxt = 1'b1;
          end else if (!txa_nxt) txq_nxt = 1'b1;
          else if (stf_nxt) txq_nxt = ~last_nxt;
          else if (cnt_nxt < ndn) txq_nxt = sh_nxt[81];
          else txq_nxt = crc_nxt[14];
        end
        S_CDEL: begin
          if (!b || (!txa_r && crc_r != 15'h0000)) err = 1'b1;
          st_nxt = S_ACK;
          txq_nxt = txa_r;                                  // receiver acks
        end
        S_ACK: begin
          if (txa_r && b && !loopback_select) err = 1'b1;
          st_nxt = S_ADEL;
          txq_nxt = 1'b1;
        end
        S_ADEL: begin
          if (!b) err = 1'b1;
          st_nxt = S_EOF;
          cnt_nxt = 7'h00;
        end
        S_EOF: begin
          if (!b) begin
            if (cnt_r < `CTB_EOF_BITS) err = 1'b1;
            st_nxt = S_WAIT;
            cnt_nxt = 7'h00;
          end else begin
            if (cnt_r == `CTB_EOF_BITS - 7'h01) begin
              done_tx = txa_r;
              done_rx = basic & (~txa_r | loopback_select);
              txa_nxt = 1'b0;
            end
            if (cnt_r == `CTB_EOFINT_END) st_nxt = S_IDLE;
            cnt_nxt = cnt_r + 7'h01;
          end
        end
        S_ERR: begin
          if (cnt_r == `CTB_FLAG_END) begin
            st_nxt = S_WAIT;
            cnt_nxt = 7'h00;
            txq_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 7'h01;
          end
        end
        default: st_nxt = S_WAIT;
      endcase
      if (err) begin                    // retry only while busy stays set
        st_nxt = S_ERR;
        cnt_nxt = 7'h00;
        txq_nxt = 1'b0;
        txa_nxt = 1'b0;
      end
    end
  end

  // engine state and pin drive
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_WAIT;
      cnt_r <= 7'h00;
      sh_r <= 82'h0;
      crc_r <= 15'h0000;
      run_r <= 3'h0;
      dlc_r <= 4'h0;
      last_r <= 1'b1;
      stf_r <= 1'b0;
      txa_r <= 1'b0;
      txq_r <= 1'b1;
      txi_r <= 1'b1;
      pin_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      crc_r <= crc_nxt;
      run_r <= run_nxt;
      dlc_r <= dlc_nxt;
      last_r <= last_nxt;
      stf_r <= stf_nxt;
      txa_r <= txa_nxt;
      txq_r <= txq_nxt;
      if (bs || init) txi_r <= init ? 1'b1 : txq_r;         // bit starts
      case (txsel)
        2'b01:   pin_r <= ~spp;
        2'b10:   pin_r <= 1'b0;
        2'b11:   pin_r <= 1'b1;
        default: pin_r <= silent ? 1'b1 : txi_r;
      endcase
    end
  end
  assign bus_tx_pin = pin_r;

  // axi write channel: address and data taken in either order
  wire wr_go  = aw_h_r & w_h_r & ~bv_r;
  wire [1:0] ws = w_s_r;
  // lane-merged write values, cut to each register's width on purpose
  wire [15:0] ctl_m  = mg({8'h00, ctl_r}, w_d_r, ws);
  wire [15:0] bit_m  = mg({1'b0, bit_r}, w_d_r, ws);
  wire [15:0] tst_m  = mg({9'h000, tst_r, 2'b00}, w_d_r, ws);
  wire [15:0] brpe_m = mg({12'h000, brpe_r}, w_d_r, ws);
  assign s_axi_awready = ~aw_h_r & ~bv_r;
  assign s_axi_wready  = ~w_h_r & ~bv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rresp_r;

  // register file and basic-mode buffer updates
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      bv_r <= 1'b0;
      aw_a_r <= 12'h000;
      w_d_r <= 16'h0000;
      w_s_r <= 2'b00;
      bresp_r <= 2'b00;
      ctl_r <= `CTB_RST_CTL;
      tst_r <= 5'h00;
      bit_r <= `CTB_RST_BIT;
      brpe_r <= 4'h0;
      if1_busy_r <= 1'b0;
      if1_num_r <= `CTB_RST_CRQ;
      if1_arb_r <= 16'h0000;
      if1_mc_r <= 16'h0000;
      if1_d_r <= 64'h0;
      if2_busy_r <= 1'b0;
      if2_num_r <= `CTB_RST_CRQ;
      if2_id_r <= 11'h000;
      if2_dlc_r <= 4'h0;
      new_data_flag_r <= 1'b0;
      message_lost_flag_r <= 1'b0;
      if2_b_r <= 64'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_r <= 1'b1;
        aw_a_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_r <= 1'b1;
        w_d_r <= s_axi_wdata[15:0];
        w_s_r <= s_axi_wstrb[1:0];
      end
      if (bv_r && s_axi_bready) bv_r <= 1'b0;
      if (done_tx) if1_busy_r <= 1'b0;
      if2_busy_r <= 1'b0;
      if (if2_busy_r && basic) begin
        if2_id_r <= sh_r[81:71];
        if2_dlc_r <= sh_r[67:64];
        if2_b_r <= sh_r[63:0];
      end
      if (wr_go) begin
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
        bv_r <= 1'b1;
        bresp_r <= mapped(aw_a_r) ? 2'b00 : 2'b10;
        case (aw_a_r)
          `CTB_A_CTL:  ctl_r <= ctl_m[7:0];
          `CTB_A_BIT:  bit_r <= bit_m[14:0];
          `CTB_A_TST:  tst_r <= tst_m[6:2];
          `CTB_A_BRPE: brpe_r <= brpe_m[3:0];
          `CTB_A_IF1CRQ: begin                  // busy write wins over done
            if (ws[1]) if1_busy_r <= w_d_r[`CTB_CRQ_BUSY];
            if (ws[0]) if1_num_r <= w_d_r[5:0];
          end
          `CTB_A_IF2CRQ: begin
            if (ws[1]) if2_busy_r <= w_d_r[`CTB_CRQ_BUSY];
            if (ws[0]) if2_num_r <= w_d_r[5:0];
          end
          `CTB_A_IF2MCTL: begin             // software may clear the flags
            if (ws[1]) new_data_flag_r <= w_d_r[`CTB_MC_NEW_DATA_FLAG];
            if (ws[1]) message_lost_flag_r <= w_d_r[`CTB_MC_MESSAGE_LOST_FLAG];
          end
          default: ;
        endcase
        if (!if1_busy_r) begin
          case (aw_a_r)
            `CTB_A_IF1ARB2: if1_arb_r <= mg(if1_arb_r, w_d_r, ws);
            `CTB_A_IF1MCTL: if1_mc_r <= mg(if1_mc_r, w_d_r, ws);
            `CTB_A_IF1DA1: if1_d_r[15:0] <= mg(if1_d_r[15:0], w_d_r, ws);
            `CTB_A_IF1DA2: if1_d_r[31:16] <= mg(if1_d_r[31:16], w_d_r, ws);
            `CTB_A_IF1DB1: if1_d_r[47:32] <= mg(if1_d_r[47:32], w_d_r, ws);
            `CTB_A_IF1DB2: if1_d_r[63:48] <= mg(if1_d_r[63:48], w_d_r, ws);
            default: ;
          endcase
        end
      end
      if (done_rx) begin                    // store beats a software clear
        if2_id_r <= al[81:71];
        if2_dlc_r <= al[67:64];
        if2_b_r <= al[63:0];
        new_data_flag_r <= 1'b1;
        message_lost_flag_r <= new_data_flag_r;
      end
    end
  end

  // read mux; iface two control shows only flags and dlc
  always @* begin
    case (s_axi_araddr & 12'hFFC)
      `CTB_A_CTL:     rdv = {8'h00, ctl_r};
      `CTB_A_BIT:     rdv = {1'b0, bit_r};
      `CTB_A_TST:     rdv = {8'h00, s2_r, tst_r, 2'b00};
      `CTB_A_BRPE:    rdv = {12'h000, brpe_r};
      `CTB_A_IF1CRQ:  rdv = {if1_busy_r, 9'h000, if1_num_r};
      `CTB_A_IF1ARB2: rdv = if1_arb_r;
      `CTB_A_IF1MCTL: rdv = if1_mc_r;
      `CTB_A_IF1DA1:  rdv = if1_d_r[15:0];
      `CTB_A_IF1DA2:  rdv = if1_d_r[31:16];
      `CTB_A_IF1DB1:  rdv = if1_d_r[47:32];
      `CTB_A_IF1DB2:  rdv = if1_d_r[63:48];
      `CTB_A_IF2CRQ:  rdv = {if2_busy_r, 9'h000, if2_num_r};
      `CTB_A_IF2ARB2: rdv = {3'b000, if2_id_r, 2'b00};
      `CTB_A_IF2MCTL: rdv = {new_data_flag_r, message_lost_flag_r, 10'h000, if2_dlc_r};
      `CTB_A_IF2DA1:  rdv = sw16(if2_b_r[63:48]);
      `CTB_A_IF2DA2:  rdv = sw16(if2_b_r[47:32]);
      `CTB_A_IF2DB1:  rdv = sw16(if2_b_r[31:16]);
      `CTB_A_IF2DB2:  rdv = sw16(if2_b_r[15:0]);
      default:        rdv = 16'h0000;
    endcase
  end

  // read channel, one registered answer at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end else if (s_axi_arvalid && !rv_r) begin
      rv_r <= 1'b1;
      rd_r <= {16'h0000, rdv};
      rresp_r <= mapped(s_axi_araddr & 12'hFFC) ? 2'b00 : 2'b10;
    end else if (rv_r && s_axi_rready) begin
      rv_r <= 1'b0;
    end
  end
endmodule

// [tb/ctb_bus_node.sv]
// bus model: transceiver wire with an optional disturbing node on rx
`timescale 1ns/10ps
module ctb_bus_node (
  input  wire aclk,
  input  wire tx,
  input  wire noise,
  output wire rx
);
  logic [3:0] cnt_r = 4'h0;
  // free-running pattern so a disturbed rx never looks settled
  always @(posedge aclk) cnt_r <= cnt_r + 4'h1;
  // dominant wins on the wire; the disturbing node pulls low half the time
  assign rx = tx & ~(noise & cnt_r[3]);
endmodule

// [tb/ctb_can_core_checker.sv]
// concurrent checks on the register bus and the tx pin of the can core
`timescale 1ns/10ps
`include "ctb_regs.vh"
module ctb_can_core_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        bus_tx_pin
);
  logic [7:0] ctl_r;
  logic [7:0] tst_r;
  wire        wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid
                      & s_axi_wready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shadow of mode bits, taken early so pin checks allow for the lag
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= 8'h01;
      tst_r <= 8'h00;
    end else if (wr_go && s_axi_awaddr[11:2] == 10'h005) begin
      tst_r <= s_axi_wdata[7:0];
    end else if (wr_go && s_axi_awaddr[11:2] == 10'h000) begin
      ctl_r <= s_axi_wdata[7:0];
    end
  end
  a_rst_idle: assert property ($rose(aresetn) |-> s_axi_awready
    && s_axi_arready && !s_axi_bvalid && bus_tx_pin)
    else $error("bus not idle after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (wr_go |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data moved before taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");
  a_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while answering");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h004 |=> s_axi_rresp == 2'b10
    && s_axi_rdata == 32'h0000_0000) else $error("unmapped read accepted");
  a_combo_quiet: assert property (
    (ctl_r[7] && tst_r[6:3] == 4'b0011)[*4] |-> bus_tx_pin)
    else $error("tx active in quiet loop");
  a_force_low: assert property (
    (ctl_r[7] && tst_r[6:5] == 2'b10)[*4] |-> !bus_tx_pin)
    else $error("tx not forced low");
  a_force_high: assert property (
    (ctl_r[7] && tst_r[6:5] == 2'b11)[*4] |-> bus_tx_pin)
    else $error("tx not forced high");
  a_test_off: assert property (
    (!ctl_r[7] && ctl_r[0])[*4] |-> bus_tx_pin)
    else $error("tx active in init");
  c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_low: cover property (!bus_tx_pin);
endmodule
bind ctb_can_core ctb_can_core_checker chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_tx_pin);

// [tb/test_can_test_modes_bit_timing.sv]
// self-checking bench: test modes, tx override, bit timing, basic mode
`timescale 1ns/10ps
`include "ctb_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_can_test_modes_bit_timing;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic        noise = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid, tx, rx;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [33:0] exp_q[$], msk_q[$];
  logic [33:0] ex, mk, pay;
  logic [31:0] seed = 32'hb4e6;
  logic [15:0] d, rb;
  int          error_cnt = 0, n_checks = 0, lows, k, q;
  logic [15:0] bit_v[3] = '{16'h2303, 16'h1200, 16'h2300};
  logic [3:0]  pe_v[3] = '{4'h0, 4'h0, 4'h1};
  always #5 aclk = ~aclk;
  ctb_can_core dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_rx_pin(rx),
    .bus_tx_pin(tx));
  ctb_bus_node node (.aclk(aclk), .tx(tx), .noise(noise), .rx(rx));
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // every answer is judged against the oldest note, bus order is strict
  always @(posedge aclk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      pay = rvalid ? {rresp, rdata} : {bresp, 32'h0000_0000};
      ex = exp_q.pop_front();
      mk = msk_q.pop_front();
      `CHK(pay & mk, ex)
    end
  end
  task automatic wr(input [11:0] a, input [15:0] v, input [1:0] r);
    int i;
    exp_q.push_back({r, 32'h0000_0000});
    msk_q.push_back({2'b11, 32'h0000_0000});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    if (i == 50) begin
      error_cnt++;
      test_done;
    end
  endtask
  task automatic rd(input [11:0] a, input [15:0] e, input [15:0] m,
                    input [1:0] r);
    int i;
    exp_q.push_back({r, 16'h0000, e & m});
    msk_q.push_back({2'b11, 16'hffff, m});
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rb = rdata[15:0];
    rready <= 0;
    if (i == 50) begin
      error_cnt++;
      test_done;
    end
  endtask
  // counts cycles with the pin low; the design's own sample-point pulse
  task automatic count(input int n);
    lows = 0;
    repeat (n) begin
      @(posedge aclk);
      if (tx !== 1'b1) lows++;
    end
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(`CTB_A_CTL, 16'h0001, 16'hffff, 2'b00);
    rd(`CTB_A_BIT, 16'h2301, 16'hffff, 2'b00);
    rd(`CTB_A_TST, 16'h0000, 16'hff7f, 2'b00);
    rd(`CTB_A_IF1CRQ, 16'h0001, 16'hffff, 2'b00);
    rd(12'h004, 16'h0000, 16'hffff, 2'b10);
    wr(12'h004, 16'h1234, 2'b10);
    wr(`CTB_A_TST, 16'h0040, 2'b00);
    count(40);
    `CHK(lows, 0)
    wr(`CTB_A_TST, 16'h0000, 2'b00);
    wr(`CTB_A_CTL, 16'h0080, 2'b00);
    rd(`CTB_A_TST, 16'h0080, 16'h0080, 2'b00);
    $display("test reset and test enable done");
    // default timing: (3 + 2 + 3) quanta of 2 clocks make 16 clocks
    for (k = 0; k < 4; k++) begin
      wr(`CTB_A_TST, 16'(k) << 5, 2'b00);
      repeat (40) @(posedge aclk);
      count(48);
      `CHK(lows, k == 1 ? 3 : (k == 2 ? 48 : 0))
    end
    $display("test tx override done");
    wr(`CTB_A_TST, 16'h0020, 2'b00);
    // bit length worked out from the fields, pulse count over four bits
    for (k = 0; k < 3; k++) begin
      q = (bit_v[k][11:8] + bit_v[k][14:12] + 3)
          * ({pe_v[k], bit_v[k][5:0]} + 1);
      wr(`CTB_A_BRPE, {12'h000, pe_v[k]}, 2'b00);
      wr(`CTB_A_BIT, bit_v[k], 2'b00);
      repeat (2 * q) @(posedge aclk);
      count(4 * q);
      `CHK(lows, 4)
    end
    wr(`CTB_A_BRPE, 16'h0000, 2'b00);
    wr(`CTB_A_BIT, 16'h2301, 2'b00);
    wr(`CTB_A_TST, 16'h0000, 2'b00);
    $display("test bit timing done");
    d = 16'($random(seed));
    wr(`CTB_A_TST, 16'h001c, 2'b00);
    noise <= 1;
    wr(`CTB_A_IF1ARB2, 16'h0a5c, 2'b00);
    wr(`CTB_A_IF1MCTL, 16'h0002, 2'b00);
    wr(`CTB_A_IF1DA1, d, 2'b00);
    wr(`CTB_A_IF1CRQ, 16'h8005, 2'b00);
    wr(`CTB_A_IF1DA1, ~d, 2'b00);
    rd(`CTB_A_IF1DA1, d, 16'hffff, 2'b00);
    rd(`CTB_A_IF1CRQ, 16'h8000, 16'h8000, 2'b00);
    for (k = 0; k < 600 && rb[15] !== 1'b0; k++)
      rd(`CTB_A_IF1CRQ, 16'h0000, 16'h0000, 2'b00);
    `CHK(rb[15], 1'b0)
    rd(`CTB_A_IF2DA1, d, 16'hffff, 2'b00);
    rd(`CTB_A_IF2ARB2, 16'h0a5c, 16'h1ffc, 2'b00);
    rd(`CTB_A_IF2MCTL, 16'h8002, 16'hffff, 2'b00);
    noise <= 0;
    wr(`CTB_A_IF2CRQ, 16'h8000, 2'b00);
    rd(`CTB_A_IF2CRQ, 16'h0000, 16'h8000, 2'b00);
    $display("test basic loop transfer done");
    wr(`CTB_A_TST, 16'h000c, 2'b00);
    wr(`CTB_A_IF1CRQ, 16'h8000, 2'b00);
    count(2000);
    `CHK(lows, 0)
    rd(`CTB_A_IF1CRQ, 16'h8000, 16'h8000, 2'b00);
    wr(`CTB_A_IF1CRQ, 16'h0000, 2'b00);
    rd(`CTB_A_IF1CRQ, 16'h0000, 16'h8000, 2'b00);
    count(800);
    `CHK(lows, 0)
    $display("test silent and abort done");
    test_done;
  end
endmodule
